// >>> verilog/tpsc_cfg.svh
// Offsets, field positions and reset values of the power and status bank.
// Assumes inclusion by bare name from the package and the tpsc_bank module.
`ifndef TPSC_CFG_SVH
`define TPSC_CFG_SVH

`define TPSC_ADDR_CTRL      8'h00
`define TPSC_ADDR_TOUCH     8'h03
`define TPSC_ADDR_RAMP      8'h04
`define TPSC_ADDR_NOISE     8'h0A
`define TPSC_CTRL_RESET     8'h00
`define TPSC_FLAGS_RESET    8'h00
`define TPSC_BIT_LPSCAN     5
`define TPSC_BIT_LOWEST     4
`define TPSC_BIT_IRQ        0
`define TPSC_NCH            8

`endif

// >>> verilog/tpsc_pkg.sv
// Types shared by the power and status bank.
// Assumes tpsc_cfg.svh is on the include path.
`include "tpsc_cfg.svh"

package tpsc_pkg;
   typedef logic [`TPSC_NCH-1:0] tpsc_ch_t;

   typedef enum logic [2:0] {
      TPSC_ACTIVE  = 3'h1,
      TPSC_STANDBY = 3'h2,
      TPSC_SLEEP   = 3'h4
   } tpsc_pwr_e;
endpackage : tpsc_pkg

// >>> verilog/tpsc_touch_track.sv
// Per-channel touch tracker with noise gating and standby release.
// Assumes events from the detector are one-cycle pulses on clk.
`timescale 1ns/1ps

module tpsc_touch_track (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // Control
   input  wire logic             sleep_clear,
   input  wire tpsc_pkg::tpsc_ch_t scan_mask,
   input  wire tpsc_pkg::tpsc_ch_t noise,
   // Detector events
   input  wire tpsc_pkg::tpsc_ch_t touch_evt,
   input  wire tpsc_pkg::tpsc_ch_t release_evt,
   // Result
   output tpsc_pkg::tpsc_ch_t       touched,
   output tpsc_pkg::tpsc_ch_t       new_touch,
   output tpsc_pkg::tpsc_ch_t       release_pulse
);
   typedef struct packed {
      tpsc_pkg::tpsc_ch_t held;
      tpsc_pkg::tpsc_ch_t newt;
      tpsc_pkg::tpsc_ch_t rel;
   } tpsc_trk_s;

   tpsc_trk_s st_reg;
   tpsc_trk_s st_next;

   always_comb begin
      tpsc_pkg::tpsc_ch_t valid;
      tpsc_pkg::tpsc_ch_t drop;
      valid = ~noise;
      drop  = st_reg.held & ~scan_mask;
      st_next.newt = touch_evt & valid & scan_mask & ~st_reg.held;
      st_next.rel  = ((release_evt & valid) | drop) & st_reg.held;
      st_next.held = (st_reg.held | st_next.newt) & ~st_next.rel;
      if (sleep_clear) begin
         st_next = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign touched       = st_reg.held;
   assign new_touch     = st_reg.newt;
   assign release_pulse = st_reg.rel;
endmodule : tpsc_touch_track

// >>> verilog/tpsc_bank.sv
// Power state, interrupt flag and status flags of the touch controller.
// Assumes a serial engine gives one-cycle rd/wr strobes with address and data.
//
// Behaviour
// - Standby scans only standby-selected sensors.
// - Standby keeps linked and host LEDs running.
// - Unscanned sensor releases once, then stays untouched.
// - Standby holds touch flags until host reads.
// - Deep sleep stops scan, LEDs, clears flags.
// - Wake pin or addressed transfer ends sleep.
// - Single-wire link mode ignores deep sleep.
// - Pending flag set only with alert asserted.
// - Host zero-write clears pending, alert, stale flags.
// - Wake output drops when pending clears.
// - Four-wire SPI leaves alert undriven.
// - Touch flags: bit n-1 for sensor n.
// - Still-touched sensor keeps flag, no interrupt.
// - Ramp-done flag per LED after ramp.
// - Noise flag set from analog report.
// - Noisy channel makes no touch decisions.
// - Noise flag follows report, not latched.
`timescale 1ns/1ps
`include "tpsc_cfg.svh"

module tpsc_bank (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               reset,
   // Register port from the serial engine
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   input  wire logic [7:0]         reg_addr,
   input  wire logic [7:0]         reg_wdata,
   output logic      [7:0]         reg_rdata,
   // Link mode and activity
   input  wire logic               link_single_wire,
   input  wire logic               link_spi_4wire,
   input  wire logic               link_addressed,
   // Wake pin and configuration
   input  wire logic               wake_in,
   input  wire logic               wake_on_touch_en,
   // Sensor side
   input  wire tpsc_pkg::tpsc_ch_t standby_sel,
   input  wire tpsc_pkg::tpsc_ch_t irq_en,
   input  wire tpsc_pkg::tpsc_ch_t touch_evt,
   input  wire tpsc_pkg::tpsc_ch_t release_evt,
   input  wire tpsc_pkg::tpsc_ch_t noise_report,
   input  wire tpsc_pkg::tpsc_ch_t ramp_done_evt,
   // Outputs to scan engine and LEDs
   output tpsc_pkg::tpsc_ch_t      scan_enable,
   output logic                    led_enable,
   output logic                    standby_active,
   output logic                    sleep_active,
   // Alert pin (open drain, low active) and wake pin
   output logic                    alert_n_out,
   output logic                    alert_n_oe_n,
   output logic                    wake_out
);
   typedef struct packed {
      logic                lpscan;
      logic                lowest;
      logic                irq;
      logic                wake;
      logic                alert;
      tpsc_pkg::tpsc_ch_t  touchf;
      tpsc_pkg::tpsc_ch_t  rampf;
      tpsc_pkg::tpsc_ch_t  noisef;
      tpsc_pkg::tpsc_ch_t  scan;
      logic                leds;
      logic                oe_n;
      logic [7:0]          rdata;
   } tpsc_bank_s;

   tpsc_bank_s st_reg;
   tpsc_bank_s st_next;

   tpsc_pkg::tpsc_ch_t touched;
   tpsc_pkg::tpsc_ch_t new_touch;
   tpsc_pkg::tpsc_ch_t rel_pulse;
   logic               sleep_eff;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   assign sleep_eff = st_reg.lowest & ~link_single_wire;

   tpsc_touch_track u_track (
      .clk           (clk),
      .reset         (reset),
      .sleep_clear   (sleep_eff),
      .scan_mask     (st_reg.scan),
      .noise         (noise_report),
      .touch_evt     (touch_evt),
      .release_evt   (release_evt),
      .touched       (touched),
      .new_touch     (new_touch),
      .release_pulse (rel_pulse)
   );

   always_comb begin
      logic               wr_ctrl;
      logic               rd_touch;
      logic               irq_clr;
      logic               raise;
      tpsc_pkg::tpsc_ch_t stale;
      st_next  = st_reg;
      wr_ctrl  = reg_wr & hit(reg_addr, `TPSC_ADDR_CTRL);
      rd_touch = reg_rd & hit(reg_addr, `TPSC_ADDR_TOUCH);
      irq_clr  = wr_ctrl & ~reg_wdata[`TPSC_BIT_IRQ];
      raise    = |(new_touch & irq_en);
      stale    = st_reg.touchf & ~touched;

      if (wr_ctrl) begin
         st_next.lpscan = reg_wdata[`TPSC_BIT_LPSCAN];
         st_next.lowest = reg_wdata[`TPSC_BIT_LOWEST];
         // Zero clears; one is ignored
         if (!reg_wdata[`TPSC_BIT_IRQ]) begin
            st_next.irq = 1'b0;
         end
      end

      // Flags: new touches set, stale ones clear on pending clear or touch read
      st_next.touchf = st_reg.touchf | new_touch;
      if (irq_clr) begin
         st_next.touchf = (st_reg.touchf & touched) | new_touch;
         st_next.alert  = 1'b0;
         st_next.wake   = 1'b0;
      end else if (rd_touch && !st_reg.lpscan) begin
         st_next.touchf = stale ^ st_reg.touchf | new_touch;
      end else if (rd_touch) begin
         st_next.touchf = (st_reg.touchf & touched) | new_touch;
      end
      st_next.rampf  = st_reg.rampf | ramp_done_evt;
      if (irq_clr) begin
         st_next.rampf = ramp_done_evt;
      end
      st_next.noisef = noise_report;

      // Raising an interrupt: alert first, pending follows it
      if (raise) begin
         st_next.alert = 1'b1;
         if (st_reg.lpscan && wake_on_touch_en) begin
            st_next.wake = 1'b1;
         end
      end
      if (st_reg.alert) begin
         st_next.irq = 1'b1;
         if (irq_clr) begin
            st_next.irq = raise;
         end
      end

      // Wake pin or addressed traffic ends deep sleep
      if (wake_in || link_addressed) begin
         st_next.lowest = 1'b0;
      end

      if (sleep_eff) begin
         st_next.touchf = '0;
         st_next.rampf  = '0;
         st_next.noisef = '0;
         st_next.irq    = 1'b0;
         st_next.alert  = 1'b0;
         st_next.wake   = 1'b0;
      end

      // Scan selection and LED enable
      if (st_next.lowest && !link_single_wire) begin
         st_next.scan = '0;
         st_next.leds = 1'b0;
      end else if (st_next.lpscan) begin
         st_next.scan = standby_sel;
         st_next.leds = 1'b1;
      end else begin
         st_next.scan = '1;
         st_next.leds = 1'b1;
      end
      st_next.oe_n = ~st_next.alert | link_spi_4wire;

      unique case (1'b1)
         hit(reg_addr, `TPSC_ADDR_CTRL):  st_next.rdata = {2'b00, st_reg.lpscan,
                                                 st_reg.lowest, 3'b000, st_reg.irq};
         hit(reg_addr, `TPSC_ADDR_TOUCH): st_next.rdata = st_reg.touchf;
         hit(reg_addr, `TPSC_ADDR_RAMP):  st_next.rdata = st_reg.rampf;
         hit(reg_addr, `TPSC_ADDR_NOISE): st_next.rdata = st_reg.noisef;
         default:                         st_next.rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_reg        <= '0;
         st_reg.scan   <= '1;
         st_reg.leds   <= 1'b1;
         st_reg.oe_n   <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata      = st_reg.rdata;
   assign scan_enable    = st_reg.scan;
   assign led_enable     = st_reg.leds;
   assign standby_active = st_reg.lpscan;
   assign sleep_active   = st_reg.lowest;
   assign alert_n_out    = 1'b0;
   assign alert_n_oe_n   = st_reg.oe_n;
   assign wake_out       = st_reg.wake;
endmodule : tpsc_bank

// >>> tb/tpsc_monitor.sv
// Port checks for the power and status bank.
// Assumes binding to tpsc_bank: one clock, synchronous reset.
`timescale 1ns/1ps
module tpsc_monitor (
   // Clock and reset
   input wire logic               clk,
   input wire logic               reset,
   // Register port, link, wake pin
   input wire logic               reg_wr,
   input wire logic [7:0]         reg_addr,
   input wire logic [7:0]         reg_wdata,
   input wire logic               link_spi_4wire,
   input wire logic               link_single_wire,
   input wire logic               link_addressed,
   input wire logic               wake_in,
   // Sensor side
   input wire tpsc_pkg::tpsc_ch_t standby_sel,
   input wire tpsc_pkg::tpsc_ch_t irq_en,
   input wire tpsc_pkg::tpsc_ch_t touch_evt,
   // Outputs
   input wire tpsc_pkg::tpsc_ch_t scan_enable,
   input wire logic               led_enable,
   input wire logic               standby_active,
   input wire logic               sleep_active,
   input wire logic               alert_n_oe_n,
   input wire logic               wake_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_reset_state: assert property (disable iff (1'b0) reset |=> scan_enable == 8'hFF
      && alert_n_oe_n && !wake_out) else $error("bad reset state");
   a_active_scan: assert property (!standby_active && !sleep_active |->
      scan_enable == 8'hFF && led_enable) else $error("active scan wrong");
   a_standby_scan: assert property (standby_active && !sleep_active && $stable(standby_sel)
      |-> scan_enable == standby_sel) else $error("standby scan wrong");
   a_sleep_quiet: assert property (sleep_active && !link_single_wire
      && !$past(link_single_wire) |-> scan_enable == 8'h00 && !led_enable
      && alert_n_oe_n && !wake_out) else $error("sleep not quiet");
   a_wake_ends_sleep: assert property (sleep_active && (wake_in || link_addressed)
      |=> !sleep_active) else $error("sleep not ended");
   a_masked_touch: assert property ($fell(alert_n_oe_n)
      |-> ($past(touch_evt, 2) & irq_en) != 8'h00) else $error("alert without cause");
   a_pending_clear: assert property (reg_wr && reg_addr == 8'h00 && !reg_wdata[0]
      && touch_evt == 8'h00 && $past(touch_evt) == 8'h00 |=> alert_n_oe_n && !wake_out)
      else $error("clear left alert or wake");
   a_wake_in_standby: assert property ($rose(wake_out) |-> standby_active)
      else $error("wake outside standby");
   a_spi4_quiet: assert property (link_spi_4wire && $past(link_spi_4wire)
      |-> alert_n_oe_n) else $error("alert driven in spi4");
   c_alert: cover property ($fell(alert_n_oe_n));
   c_sleep_wake: cover property (sleep_active ##1 !sleep_active);
   c_wake_out: cover property ($rose(wake_out));
endmodule : tpsc_monitor

bind tpsc_bank tpsc_monitor mon (.clk(clk), .reset(reset), .reg_wr(reg_wr),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .link_spi_4wire(link_spi_4wire),
   .link_single_wire(link_single_wire),
   .link_addressed(link_addressed), .wake_in(wake_in), .standby_sel(standby_sel),
   .irq_en(irq_en), .touch_evt(touch_evt), .scan_enable(scan_enable),
   .led_enable(led_enable), .standby_active(standby_active), .sleep_active(sleep_active),
   .alert_n_oe_n(alert_n_oe_n), .wake_out(wake_out));

// >>> tb/tpsc_host_model.sv
// Host side of the register port; strobes last one cycle.
// Assumes reg_rdata answers the address one cycle later.
`timescale 1ns/1ps
module tpsc_host_model (
   // Clock
   input  wire logic       clk,
   // Register port
   output logic            reg_wr,
   output logic            reg_rd,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'hFF;
      reg_wdata = 8'h5A;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;  // Zero in bit 0 clears pending
      @(negedge clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask : rd
endmodule : tpsc_host_model

// >>> tb/tpsc_bank_tb.sv
// Self-checking bench of the power and status bank.
// Assumes design, host model and checker are compiled first.
`timescale 1ns/1ps
module tpsc_bank_tb;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic reg_wr, reg_rd, link_single_wire, link_spi_4wire, link_addressed;
   logic wake_in, wake_on_touch_en, led_enable, standby_active, sleep_active;
   logic alert_n_out, alert_n_oe_n, wake_out;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, rnd;
   tpsc_pkg::tpsc_ch_t standby_sel, irq_en, touch_evt, release_evt, noise_report;
   tpsc_pkg::tpsc_ch_t ramp_done_evt, scan_enable;
   logic [7:0] amap [5] = '{8'h00, 8'h03, 8'h04, 8'h0A, 8'h55};
   int failures, compares, seed;
   always #5 clk = ~clk;
   tpsc_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   tpsc_bank uut (.clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .link_single_wire(link_single_wire), .link_spi_4wire(link_spi_4wire),
      .link_addressed(link_addressed), .wake_in(wake_in), .wake_on_touch_en(wake_on_touch_en),
      .standby_sel(standby_sel), .irq_en(irq_en), .touch_evt(touch_evt),
      .release_evt(release_evt), .noise_report(noise_report), .ramp_done_evt(ramp_done_evt),
      .scan_enable(scan_enable), .led_enable(led_enable), .standby_active(standby_active),
      .sleep_active(sleep_active), .alert_n_out(alert_n_out), .alert_n_oe_n(alert_n_oe_n),
      .wake_out(wake_out));
   function automatic logic [7:0] gate(input logic [7:0] t, input logic [7:0] n);
      return t & ~n;
   endfunction : gate
   task automatic tally_and_finish;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", n, e, g);
         failures++;
      end
   endtask : chk
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, rv);
      chk($sformatf("register %h", a), e, rv);
   endtask : rdchk
   task automatic pulse(input logic [7:0] t, input logic [7:0] r, input logic [7:0] m);
      @(negedge clk);
      touch_evt = t;
      release_evt = r;
      ramp_done_evt = m;
      @(negedge clk);
      {touch_evt, release_evt, ramp_done_evt} = '0;
      repeat (3) @(negedge clk);
   endtask : pulse
   // Watchdog: a hang counts as a mismatch
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      tally_and_finish();
   end
   initial begin
      seed = 32'h0f3c1642;
      {link_single_wire, link_spi_4wire, link_addressed, wake_in, wake_on_touch_en} = '0;
      {standby_sel, touch_evt, release_evt, noise_report, ramp_done_evt} = '0;
      irq_en = 8'hFF;
      repeat (3) @(negedge clk);
      reset = 1'b0;
      chk("scan_enable", 8'hFF, scan_enable);
      foreach (amap[i]) rdchk(amap[i], 8'h00);
      pulse(8'h21, 8'h00, 8'h00);
      rdchk(8'h03, 8'h21);
      rdchk(8'h00, 8'h01);
      host.wr(8'h00, 8'h01);
      rdchk(8'h00, 8'h01);
      pulse(8'h00, 8'h20, 8'h00);
      host.wr(8'h00, 8'h00);
      rdchk(8'h03, 8'h01);
      chk("alert_n_oe_n", 8'h01, {7'h00, alert_n_oe_n});
      pulse(8'h00, 8'h01, 8'h00);
      host.wr(8'h00, 8'h00);
      rdchk(8'h03, 8'h00);
      rnd = $random(seed);
      pulse(8'h00, 8'h00, rnd);
      rdchk(8'h04, rnd);
      rnd = $random(seed);
      @(negedge clk);
      noise_report = rnd;
      pulse(8'hFF, 8'h00, 8'h00);
      rdchk(8'h0A, rnd);
      rdchk(8'h03, gate(8'hFF, rnd));
      noise_report = 8'h00;
      rdchk(8'h0A, 8'h00);
      pulse(8'h00, 8'hFF, 8'h00);
      host.wr(8'h00, 8'h00);
      irq_en = 8'hFD;
      pulse(8'h02, 8'h00, 8'h00);
      rdchk(8'h00, 8'h00);
      pulse(8'h00, 8'h02, 8'h00);
      irq_en = 8'hFF;
      pulse(8'h00, 8'h00, 8'h81);
      host.wr(8'h00, 8'h10);
      rdchk(8'h04, 8'h00);
      rdchk(8'h00, 8'h10);
      wake_in = 1'b1;
      @(negedge clk);
      wake_in = 1'b0;
      rdchk(8'h00, 8'h00);
      host.wr(8'h00, 8'h10);
      link_addressed = 1'b1;
      @(negedge clk);
      link_addressed = 1'b0;
      rdchk(8'h00, 8'h00);
      link_single_wire = 1'b1;
      host.wr(8'h00, 8'h10);
      @(negedge clk);
      chk("scan_enable", 8'hFF, scan_enable);
      chk("led_enable", 8'h01, {7'h00, led_enable});
      host.wr(8'h00, 8'h00);
      link_single_wire = 1'b0;
      rnd = $random(seed);
      standby_sel = (rnd | 8'h08) & 8'hEF;
      wake_on_touch_en = 1'b1;
      pulse(8'h10, 8'h00, 8'h00);
      host.wr(8'h00, 8'h21);
      host.wr(8'h00, 8'h20);
      rdchk(8'h03, 8'h00);
      chk("scan_enable", standby_sel, scan_enable);
      pulse(8'h08, 8'h00, 8'h00);
      chk("wake_out", 8'h01, {7'h00, wake_out});
      pulse(8'h00, 8'h08, 8'h00);
      rdchk(8'h03, 8'h08);
      rdchk(8'h03, 8'h00);
      host.wr(8'h00, 8'h20);
      chk("wake_out", 8'h00, {7'h00, wake_out});
      host.wr(8'h00, 8'h00);
      link_spi_4wire = 1'b1;
      pulse(8'h40, 8'h00, 8'h00);
      chk("alert_n_oe_n", 8'h01, {7'h00, alert_n_oe_n});
      tally_and_finish();
   end
endmodule : tpsc_bank_tb
